// *** pkg/aux_map.svh ***
// Register offsets, field positions, reset values and timing figures of the auxiliary logic.
// Definitions only; included by the design files by bare name.
`ifndef AUX_MAP_SVH
`define AUX_MAP_SVH

`define AUX_ADDR_STATUS 6'h00
`define AUX_ADDR_MODE 6'h01
`define AUX_ADDR_IFMODE 6'h02
`define AUX_ADDR_DATA 6'h04
`define AUX_ADDR_PINCFG 6'h06
`define AUX_ADDR_CHEN 6'h10

`define AUX_RST_MODE 16'h0000
`define AUX_RST_IFMODE 16'h0000
`define AUX_RST_PINCFG 16'h0000
`define AUX_RST_CHEN 16'h0001
`define AUX_RST_DATA 24'h000000

`define AUX_CMD_READ 6
`define AUX_CONT_CMD 8'h44
`define AUX_CRC_POLY 8'h07

`define AUX_MODE_DLY_HI 10
`define AUX_MODE_DLY_LO 8

`define AUX_IF_SHORT 0
`define AUX_IF_CRC_HI 3
`define AUX_IF_CRC_LO 2
`define AUX_IF_CONT 7
`define AUX_IF_HOLD 8
`define AUX_CRC_OFF 2'h0
`define AUX_CRC_XOR 2'h1

`define AUX_PC_IE0 4
`define AUX_PC_IE1 5
`define AUX_PC_OE0 6
`define AUX_PC_OE1 7
`define AUX_PC_OE23 8
`define AUX_PC_ERRLVL 9
`define AUX_PC_ERREN_HI 11
`define AUX_PC_ERREN_LO 10
`define AUX_PC_MUX 12
`define AUX_PC_SYNC 13
`define AUX_ERR_GPO 2'h3

`define AUX_CLK_HZ 20000000
`define AUX_HZ_PER_MHZ 1000000
`define AUX_DLY_US0 0
`define AUX_DLY_US1 32
`define AUX_DLY_US2 128
`define AUX_DLY_US3 320
`define AUX_DLY_US4 800
`define AUX_DLY_US5 1600
`define AUX_DLY_US6 4000
`define AUX_DLY_US7 8000
`define AUX_ROUND_HALF 25'h000080

`endif

// *** pkg/aux_pkg.sv ***
// Types shared by the auxiliary converter logic.
// Offsets and counts live in aux_map.svh.
package aux_pkg;
   typedef enum logic [3:0] {
      AUX_IDLE = 4'b0001,
      AUX_HOLD = 4'b0010,
      AUX_SETTLE = 4'b0100,
      AUX_RUN = 4'b1000
   } aux_eng_t;
endpackage

// *** rtl/aux_chk.sv ***
// Checksum over up to MAXB message bytes, first byte in the top bits of msg.
// Purely combinational; the caller keeps msg stable while sum is used.
`timescale 1ns/1ns
`include "aux_map.svh"
module aux_chk #(
   parameter int MAXB = 5
) (
   input wire logic [8*MAXB-1:0] msg,
   input wire logic [2:0] nbytes,
   input wire logic xor_sel,
   output logic [7:0] sum
);
   always_comb begin
      logic [7:0] crc;
      logic [7:0] fold;
      logic [7:0] byte_v;
      crc = 8'h00;
      fold = 8'h00;
      byte_v = 8'h00;
      for (int b = 0; b < MAXB; b++) begin
         byte_v = msg[8*(MAXB-b)-1 -: 8];
         if (b < int'(nbytes)) begin
            fold = fold ^ byte_v; // RULE3
            // Bitwise long division; equal to appending eight zeros and reducing.
            for (int i = 7; i >= 0; i--) begin
               if (crc[7] ^ byte_v[i]) begin
                  crc = {crc[6:0], 1'b0} ^ `AUX_CRC_POLY; // RULE1
               end else begin
                  crc = {crc[6:0], 1'b0}; // RULE2
               end
            end
         end
      end
      sum = xor_sel ? fold : crc;
   end
endmodule

// *** rtl/aux_sync.sv ***
// Two-stage synchroniser for a bundle of independent levels.
// Each bit is a slow level; bundled bits are not guaranteed to arrive together.
`timescale 1ns/1ns
module aux_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// *** rtl/aux_top.sv ***
// Auxiliary logic of the converter: serial registers, checksums, pins, sync and sequencing.
// The filter outside takes conv_start and filter_reset and returns conv_done with a result.
// How it works
// (RULE1) Polynomial checksum is 8 bits, generator x^8+x^2+x+1.
// (RULE2) Remainder of message with eight zeros appended, divided by the generator.
// (RULE3) XOR checksum folds all message bytes into one byte.
// (RULE4) Two two-way pins with own enables, two outputs sharing one enable.
// (RULE5) Input-enabled two-way pin level appears in its configuration data bit.
// (RULE6) Output-enabled pin drives the level held in its data bit.
// (RULE7) Error-pin function 11 makes the error pin follow its level bit.
// (RULE8) External mux bit lets the converter time pin outputs to channel switching.
// (RULE9) Mode bits 10:8 select one of eight waits before sampling.
// (RULE10) Short-word bit rounds every result to 16 bits; cleared gives 24 bits.
// (RULE11) Data-out pin shows ready, read data during reads, then ready again.
// (RULE12) With hold bit set, read data stays until chip select rises.
// (RULE13) Enabled sync input resets filter and modulator, registers untouched.
// (RULE14) Host holds sync low at least one master clock cycle.
// (RULE15) Sync returns the sequencer to the first enabled channel.
// (RULE16) Sync low holds the filter in reset; rising edge resumes sampling.
// (RULE17) Host raises sync on a master clock rising edge for aligned devices.
// (RULE18) Single channel: sync rise starts one conversion, ready falls when done.
// (RULE19) Host drives sync low again before the next single conversion.
// (RULE20) Writes always use the polynomial; reads select none, polynomial or XOR.
// (RULE21) Checksum byte follows data and covers command plus data bytes.
// (RULE22) Mismatching write checksum sets the checksum error flag.
// (RULE23) Continuous read checksums as if command 0x44 came first.
// (RULE24) Mux mode drives pins with the index of the channel about to convert.
// (RULE25) Sync input passes a two-stage synchroniser before edge detection.
`timescale 1ns/1ns
`include "aux_map.svh"
module aux_top #(
   parameter int unsigned CYC_PER_US = `AUX_CLK_HZ / `AUX_HZ_PER_MHZ
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output wire logic dout_rdy_n,
   input wire logic sync_n,
   input wire logic bidir_pin_zero_in,
   output logic bidir_pin_zero_out,
   output logic bidir_pin_zero_oe,
   input wire logic bidir_pin_one_in,
   output logic bidir_pin_one_out,
   output logic bidir_pin_one_oe,
   output logic out_pin_two,
   output logic out_pin_two_oe,
   output logic out_pin_three,
   output logic out_pin_three_oe,
   output logic error_pin_out,
   output logic error_pin_oe,
   output logic filter_reset,
   output logic conv_start,
   output logic [3:0] active_channel,
   input wire logic conv_done,
   input wire logic [23:0] conv_result
);
   localparam int unsigned DLY_US [8] = '{`AUX_DLY_US0, `AUX_DLY_US1, `AUX_DLY_US2,
      `AUX_DLY_US3, `AUX_DLY_US4, `AUX_DLY_US5, `AUX_DLY_US6, `AUX_DLY_US7};

   logic [15:0] mode_reg;
   logic [15:0] ifmode;
   logic [15:0] pin_config_register;
   logic [15:0] chan_en;
   logic [23:0] data_reg;
   logic rdy_n;
   logic crc_err;
   logic rd_release;
   aux_pkg::aux_eng_t st;
   logic [19:0] dly;

   function automatic logic [2:0] reg_len(input logic [5:0] a, input logic sw);
      if (a == `AUX_ADDR_STATUS) begin
         reg_len = 3'd1;
      end else if (a == `AUX_ADDR_DATA) begin
         reg_len = sw ? 3'd2 : 3'd3;
      end else if (a == `AUX_ADDR_MODE || a == `AUX_ADDR_IFMODE ||
                   a == `AUX_ADDR_PINCFG || a == `AUX_ADDR_CHEN) begin
         reg_len = 3'd2;
      end else begin
         reg_len = 3'd1;
      end
   endfunction

   function automatic logic [3:0] nxt_ch(input logic [3:0] cur, input logic [15:0] en);
      logic [3:0] c;
      logic found;
      nxt_ch = cur;
      c = cur;
      found = 1'b0;
      for (int i = 0; i < 16; i++) begin
         c = c + 4'd1;
         if (en[c] && !found) begin
            nxt_ch = c;
            found = 1'b1;
         end
      end
   endfunction

   function automatic logic [15:0] round16(input logic [23:0] r);
      logic [24:0] s;
      s = {1'b0, r} + `AUX_ROUND_HALF;
      round16 = s[24] ? 16'hffff : s[23:8];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Serial link, clocked by sclk. Interface mode values (ifmode) read here are
   // only updated by the master clock side between frames, so they are static while
   // chip select is low; the host must leave chip select high for a few master clocks.

   wire logic link_clr;
   wire logic short_on;
   wire logic cont_on;
   wire logic [1:0] crc_mode;
   logic [6:0] bit_cnt;
   logic [7:0] cmd_sh;
   logic [31:0] rx;
   logic [39:0] tx;
   logic rd_on;
   logic xfer_tgl;
   logic [7:0] xfer_cmd;
   logic [31:0] xfer_rx;
   logic [7:0] lcmd;
   logic lread;
   logic [2:0] lnb;
   logic [6:0] loff;
   logic [6:0] lend;
   logic [31:0] rd_word;
   logic [31:0] rd_left;
   logic [7:0] rd_sum;
   logic [39:0] tx_load;

   assign link_clr = cs_n | ~rstn;
   assign short_on = ifmode[`AUX_IF_SHORT];
   assign cont_on = ifmode[`AUX_IF_CONT];
   assign crc_mode = ifmode[`AUX_IF_CRC_HI:`AUX_IF_CRC_LO];

   always_comb begin
      lcmd = cont_on ? `AUX_CONT_CMD : cmd_sh; // RULE23
      lread = lcmd[`AUX_CMD_READ];
      lnb = reg_len(lcmd[5:0], short_on);
      loff = cont_on ? 7'd0 : 7'd8;
      lend = loff + {1'b0, lnb, 3'b000}
         + ((lread && crc_mode == `AUX_CRC_OFF) ? 7'd0 : 7'd8); // RULE20
      if (lcmd[5:0] == `AUX_ADDR_STATUS) begin
         rd_word = {24'h000000, rdy_n, crc_err, 2'b00, active_channel};
      end else if (lcmd[5:0] == `AUX_ADDR_MODE) begin
         rd_word = {16'h0000, mode_reg};
      end else if (lcmd[5:0] == `AUX_ADDR_IFMODE) begin
         rd_word = {16'h0000, ifmode};
      end else if (lcmd[5:0] == `AUX_ADDR_DATA) begin
         rd_word = {8'h00, data_reg};
      end else if (lcmd[5:0] == `AUX_ADDR_PINCFG) begin
         rd_word = {16'h0000, pin_config_register};
      end else if (lcmd[5:0] == `AUX_ADDR_CHEN) begin
         rd_word = {16'h0000, chan_en};
      end else begin
         rd_word = 32'h00000000;
      end
      rd_left = rd_word << (6'd32 - {2'b00, lnb, 3'b000});
      tx_load = {rd_left, 8'h00};
      if (crc_mode != `AUX_CRC_OFF) begin
         tx_load = tx_load | ({32'h00000000, rd_sum} << (6'd32 - {2'b00, lnb, 3'b000})); // RULE21
      end
   end

   aux_chk #(.MAXB(5)) u_chk_rd (
      .msg({lcmd, rd_left}),
      .nbytes(lnb + 3'd1),
      .xor_sel(crc_mode == `AUX_CRC_XOR),
      .sum(rd_sum)
   );

   always_ff @(posedge sclk or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt <= 7'd0;
         cmd_sh <= 8'h00;
         rx <= 32'h00000000;
      end else begin
         if (bit_cnt != 7'h7f) begin
            bit_cnt <= bit_cnt + 7'd1;
         end
         if (bit_cnt < loff) begin
            cmd_sh <= {cmd_sh[6:0], din};
         end else begin
            rx <= {rx[30:0], din};
         end
      end
   end

   // Handed over at the last bit of each frame; kept through chip select so the
   // master clock side can still pick it up after the toggle crosses.
   always_ff @(posedge sclk or negedge rstn) begin
      if (!rstn) begin
         xfer_tgl <= 1'b0;
         xfer_cmd <= 8'h00;
         xfer_rx <= 32'h00000000;
      end else if (!cs_n && bit_cnt >= loff && bit_cnt + 7'd1 == lend) begin
         xfer_tgl <= ~xfer_tgl;
         xfer_cmd <= lcmd;
         xfer_rx <= {rx[30:0], din};
      end
   end

   always_ff @(negedge sclk or posedge link_clr) begin
      if (link_clr) begin
         tx <= 40'h0000000000;
         rd_on <= 1'b0;
      end else if (lread && bit_cnt == loff && !rd_on) begin
         tx <= tx_load;
         rd_on <= 1'b1;
      end else begin
         tx <= {tx[38:0], 1'b0};
      end
   end

   // The pin mixes both domains on purpose: ready belongs to the master clock side.
   assign dout_rdy_n = (rd_on && !rd_release) ? tx[39] : rdy_n; // RULE11

   ////////////////////////////////////////////////////////////////////////////////
   // Master clock side: crossings and register writes.

   logic [4:0] sy;
   logic xfer_q;
   logic sync_q;
   wire logic xfer_ev;
   wire logic sync_fall;
   wire logic sync_en;
   wire logic [5:0] x_addr;
   wire logic x_read;
   wire logic [2:0] x_nb;
   wire logic [31:0] wr_left;
   wire logic [15:0] wr_val;
   wire logic [7:0] wr_sum;
   wire logic wr_bad;
   wire logic wr_do;
   wire logic single;
   wire logic mux_on;
   wire logic [19:0] dly_cyc;

   aux_sync #(.W(5), .INIT(5'b00011)) u_sync (
      .clk(clk_sys),
      .rstn(rstn),
      .d({bidir_pin_one_in, bidir_pin_zero_in, xfer_tgl, cs_n, sync_n}),
      .q(sy)
   ); // RULE25

   assign xfer_ev = sy[2] ^ xfer_q;
   assign sync_en = pin_config_register[`AUX_PC_SYNC];
   assign sync_fall = sync_q && !sy[0];
   assign x_addr = xfer_cmd[5:0];
   assign x_read = xfer_cmd[`AUX_CMD_READ];
   assign x_nb = reg_len(x_addr, short_on);
   assign wr_left = {xfer_rx[31:8], 8'h00} << (6'd24 - {2'b00, x_nb, 3'b000});
   assign wr_val = xfer_rx[23:8];
   assign wr_bad = xfer_ev && !x_read && (wr_sum != xfer_rx[7:0]); // RULE22
   assign wr_do = xfer_ev && !x_read && !wr_bad;
   assign single = ($countones(chan_en) == 1);
   assign mux_on = pin_config_register[`AUX_PC_MUX];
   assign dly_cyc = 20'(DLY_US[mode_reg[`AUX_MODE_DLY_HI:`AUX_MODE_DLY_LO]] * CYC_PER_US);

   aux_chk #(.MAXB(5)) u_chk_wr (
      .msg({xfer_cmd, wr_left}),
      .nbytes(x_nb + 3'd1),
      .xor_sel(1'b0),
      .sum(wr_sum)
   ); // RULE20

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         xfer_q <= 1'b0;
         sync_q <= 1'b1;
      end else begin
         xfer_q <= sy[2];
         sync_q <= sy[0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= `AUX_RST_MODE;
         ifmode <= `AUX_RST_IFMODE;
         pin_config_register <= `AUX_RST_PINCFG;
         chan_en <= `AUX_RST_CHEN;
      end else begin
         if (wr_do && x_addr == `AUX_ADDR_MODE) begin
            mode_reg <= wr_val;
         end
         if (wr_do && x_addr == `AUX_ADDR_IFMODE) begin
            ifmode <= wr_val;
         end
         if (wr_do && x_addr == `AUX_ADDR_CHEN) begin
            chan_en <= wr_val;
         end
         if (wr_do && x_addr == `AUX_ADDR_PINCFG) begin
            pin_config_register <= wr_val;
         end
         // A sampled input level overrides a written one.
         if (pin_config_register[`AUX_PC_IE0]) begin
            pin_config_register[0] <= sy[3]; // RULE5
         end
         if (pin_config_register[`AUX_PC_IE1]) begin
            pin_config_register[1] <= sy[4]; // RULE5
         end
      end
   end

   // A bad checksum and a status read never share one frame, so set simply wins.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         crc_err <= 1'b0;
      end else if (wr_bad) begin
         crc_err <= 1'b1;
      end else if (xfer_ev && x_read && x_addr == `AUX_ADDR_STATUS) begin
         crc_err <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_release <= 1'b0;
      end else if (sy[1]) begin
         rd_release <= 1'b0;
      end else if (xfer_ev && x_read && !ifmode[`AUX_IF_HOLD]) begin
         rd_release <= 1'b1; // RULE12
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion engine and channel sequencer.

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st <= aux_pkg::AUX_IDLE;
         dly <= 20'd0;
         conv_start <= 1'b0;
         filter_reset <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         if (sync_en && sync_fall) begin
            st <= aux_pkg::AUX_HOLD; // RULE13
            filter_reset <= 1'b1; // RULE16
         end else begin
            unique case (st)
               aux_pkg::AUX_IDLE: begin
                  if (!sync_en && chan_en != 16'h0000) begin
                     st <= aux_pkg::AUX_SETTLE;
                     dly <= dly_cyc;
                  end
               end
               aux_pkg::AUX_HOLD: begin
                  if (sy[0] || !sync_en) begin
                     st <= aux_pkg::AUX_SETTLE; // RULE18
                     dly <= dly_cyc;
                     filter_reset <= 1'b0; // RULE16
                  end
               end
               aux_pkg::AUX_SETTLE: begin
                  if (dly == 20'd0) begin
                     st <= aux_pkg::AUX_RUN;
                     conv_start <= 1'b1;
                  end else begin
                     dly <= dly - 20'd1; // RULE9
                  end
               end
               aux_pkg::AUX_RUN: begin
                  if (conv_done) begin
                     if (sync_en && single) begin
                        st <= aux_pkg::AUX_IDLE; // RULE18
                     end else begin
                        st <= aux_pkg::AUX_SETTLE;
                        dly <= dly_cyc;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         active_channel <= 4'h0;
         data_reg <= `AUX_RST_DATA;
      end else begin
         // A result finishing as sync falls is kept, matching the ready flag set with it.
         if (st == aux_pkg::AUX_RUN && conv_done) begin
            data_reg <= short_on ? {8'h00, round16(conv_result)} : conv_result; // RULE10
            active_channel <= nxt_ch(active_channel, chan_en); // RULE24
         end
         if (sync_en && sync_fall) begin
            active_channel <= nxt_ch(4'hf, chan_en); // RULE15
         end
      end
   end

   // New data beats a read finishing in the same cycle.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdy_n <= 1'b1;
      end else if (st == aux_pkg::AUX_RUN && conv_done) begin
         rdy_n <= 1'b0; // RULE18
      end else if (xfer_ev && x_read && x_addr == `AUX_ADDR_DATA) begin
         rdy_n <= 1'b1; // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins. In mux mode the levels follow the channel index, so they change
   // one master clock after the sequencer advances and the settle wait covers the switch.

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bidir_pin_zero_out <= 1'b0;
         bidir_pin_zero_oe <= 1'b0;
         bidir_pin_one_out <= 1'b0;
         bidir_pin_one_oe <= 1'b0;
         out_pin_two <= 1'b0;
         out_pin_two_oe <= 1'b0;
         out_pin_three <= 1'b0;
         out_pin_three_oe <= 1'b0;
         error_pin_out <= 1'b0;
         error_pin_oe <= 1'b0;
      end else begin
         bidir_pin_zero_oe <= pin_config_register[`AUX_PC_OE0]; // RULE4
         bidir_pin_one_oe <= pin_config_register[`AUX_PC_OE1]; // RULE4
         out_pin_two_oe <= pin_config_register[`AUX_PC_OE23]; // RULE4
         out_pin_three_oe <= pin_config_register[`AUX_PC_OE23]; // RULE4
         bidir_pin_zero_out <= mux_on ? active_channel[0] : pin_config_register[0]; // RULE6
         bidir_pin_one_out <= mux_on ? active_channel[1] : pin_config_register[1]; // RULE6
         out_pin_two <= mux_on ? active_channel[2] : pin_config_register[2]; // RULE8
         out_pin_three <= mux_on ? active_channel[3] : pin_config_register[3]; // RULE8
         error_pin_oe <= pin_config_register[`AUX_PC_ERREN_HI:`AUX_PC_ERREN_LO]
            == `AUX_ERR_GPO; // RULE7
         error_pin_out <= pin_config_register[`AUX_PC_ERRLVL]; // RULE7
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   AST_PIN_SAMPLE: assert property (pin_config_register[`AUX_PC_IE0] // RULE5
      |=> pin_config_register[0] == $past(sy[3])) else $error("pin0 input not sampled");
   AST_PIN_DRIVE: assert property (!mux_on && pin_config_register[`AUX_PC_OE0] // RULE6
      |=> bidir_pin_zero_oe && bidir_pin_zero_out == $past(pin_config_register[0]))
      else $error("pin0 output level wrong");
   AST_ERR_GPO: assert property (pin_config_register[11:10] == 2'h3 // RULE7
      |=> error_pin_oe && error_pin_out == $past(pin_config_register[9]))
      else $error("error pin not a plain output");
   AST_MUX_INDEX: assert property (mux_on // RULE24
      |=> out_pin_three == $past(active_channel[3])) else $error("mux index wrong");
   AST_SYNC_HOLD: assert property (sync_en && sync_fall // RULE16
      |=> st == aux_pkg::AUX_HOLD && filter_reset ##1 (filter_reset || $past(sy[0])))
      else $error("sync did not hold filter");
   AST_SEQ_FIRST: assert property (sync_en && sync_fall // RULE15
      |=> active_channel == nxt_ch(4'hf, $past(chan_en))) else $error("sequencer not reset");
   AST_SHORT: assert property (short_on && st == aux_pkg::AUX_RUN && conv_done // RULE10
      |=> data_reg[23:16] == 8'h00 && !rdy_n) else $error("short result not rounded");
   AST_CRC_FLAG: assert property (wr_bad |=> crc_err) else $error("checksum error lost"); // RULE22
   AST_START: assert property (st == aux_pkg::AUX_HOLD && sy[0] && dly_cyc == 20'd0 // RULE18
      |-> ##[1:2] conv_start) else $error("sync rise did not start");
   AST_HOLD_DOUT: assert property (ifmode[8] && !sy[1] && !rd_release // RULE12
      |=> !rd_release) else $error("read data released early");
endmodule

// *** tb/adc_aux_io_sync_checksum_bench.sv ***
// Self-checking bench of the auxiliary converter logic with a small filter stand-in.
// Assumes aux_map.svh on the include path and the host model in aux_host.sv.
`timescale 1ns/1ns
`include "aux_map.svh"
`define CHK(a, b) tests_run++; if ((a) !== (b)) begin miscompares++; $display("mismatch at %0t: got %h want %h", $time, a, b); end
module adc_aux_io_sync_checksum_bench;
   logic clk_sys = 1'b0, rstn = 1'b0, sync_n = 1'b1, p0_in = 1'b0, p1_in = 1'b0, conv_done = 1'b0;
   logic p0_out, p0_oe, p1_out, p1_oe, o2, o2_oe, o3, o3_oe, err_out, err_oe, f_rst, c_start;
   logic [23:0] conv_result = '0, res, v;
   logic [15:0] cfg;
   logic [3:0] chan;
   logic [7:0] fcnt = '0;
   logic [1:0] crc_mode = 2'h0;
   logic [47:0] r;
   wire sclk, cs_n, din, dout_rdy_n;
   int miscompares = 0, tests_run = 0, n, dly;
   int tab[8] = '{0, 32, 128, 320, 800, 1600, 4000, 8000};
   always #25 clk_sys = ~clk_sys;
   aux_top #(.CYC_PER_US(1)) aux_top_inst (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout_rdy_n(dout_rdy_n), .sync_n(sync_n),
      .bidir_pin_zero_in(p0_in), .bidir_pin_zero_out(p0_out), .bidir_pin_zero_oe(p0_oe),
      .bidir_pin_one_in(p1_in), .bidir_pin_one_out(p1_out), .bidir_pin_one_oe(p1_oe),
      .out_pin_two(o2), .out_pin_two_oe(o2_oe), .out_pin_three(o3), .out_pin_three_oe(o3_oe),
      .error_pin_out(err_out), .error_pin_oe(err_oe), .filter_reset(f_rst),
      .conv_start(c_start), .active_channel(chan), .conv_done(conv_done),
      .conv_result(conv_result));
   aux_host aux_host_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_rdy_n));
   // Filter stand-in: settles twenty cycles after a start, aborted by its reset.
   always @(posedge clk_sys) begin
      conv_done <= (fcnt == 8'd1) && !f_rst;
      fcnt <= f_rst ? 8'd0 : (c_start ? 8'd20 : (fcnt != 8'd0 ? fcnt - 8'd1 : fcnt));
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] sum8(input logic [39:0] m, input int nb, input logic x);
      logic [7:0] c = '0;
      for (int i = nb * 8 - 1; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
      if (x) begin
         c = '0;
         for (int i = 0; i < nb; i++)
            c ^= m[i*8 +: 8];
      end
      return c;
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic limit(input int cnt, input int top);
      if (cnt >= top) begin
         miscompares++;
         $display("mismatch at %0t: wait ran out", $time);
         print_verdict();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic bad);
      logic [47:0] r;
      aux_host_inst.xfer({2'b00, a, d, sum8({2'b00, a, d}, 3, 1'b0) ^ {7'h0, bad}}, 32, r);
   endtask
   task automatic rd(input logic [5:0] a, input int nb, output logic [23:0] d);
      logic [47:0] r;
      int c;
      c = (crc_mode != 2'h0) ? 8 : 0;
      aux_host_inst.xfer(48'h40 + a << (nb * 8 + c), 8 + nb * 8 + c, r);
      d = 24'((r >> c) & ((48'h1 << (nb * 8)) - 48'h1));
      if (c != 0) begin
         `CHK(r[7:0], sum8((40'({2'b01, a}) << (nb * 8)) | 40'(d), nb + 1, crc_mode == 2'h1))
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      n = $urandom(28168);
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd(`AUX_ADDR_CHEN, 2, v);
      `CHK(v[15:0], `AUX_RST_CHEN)
      rd(6'h03, 1, v);
      `CHK(v[7:0], 8'h00)
      wr(`AUX_ADDR_MODE, 16'h0700, 1'b1);
      rd(`AUX_ADDR_STATUS, 1, v);
      `CHK(v[6], 1'b1)
      rd(`AUX_ADDR_MODE, 2, v);
      `CHK(v[15:0], `AUX_RST_MODE)
      for (int k = 1; k < 3; k++) begin
         wr(`AUX_ADDR_IFMODE, 16'(k << 2), 1'b0);
         crc_mode = 2'(k);
         cfg = 16'($urandom) & 16'h0f0f | 16'h0d90 | 16'(k - 1 << 12);
         @(posedge clk_sys) p0_in <= cfg[0] ^ 1'b1;
         p1_in <= 1'($urandom);
         wr(`AUX_ADDR_PINCFG, cfg, 1'b0);
         rd(`AUX_ADDR_PINCFG, 2, v);
         `CHK(v[0], ~cfg[0])
         `CHK(v[15:1], cfg[15:1])
         `CHK({p1_oe, o2_oe, o3_oe, err_oe, err_out, p0_oe}, {4'hf, cfg[9], 1'b0})
         // Second pass is in mux mode, where channel 0 is the only enabled channel.
         `CHK({o3, o2, p1_out, p0_out}, (k == 1) ? {cfg[3:1], ~cfg[0]} : 4'h0)
      end
      for (int k = 0; k < 2; k++) begin
         wr(`AUX_ADDR_IFMODE, {7'h0, 1'(k), 4'h0, crc_mode, 1'b0, 1'(k)}, 1'b0);
         dly = $urandom_range(7);
         wr(`AUX_ADDR_MODE, {5'h0, 3'(dly), 8'h00}, 1'b0);
         wr(`AUX_ADDR_PINCFG, 16'h2000, 1'b0);
         @(posedge clk_sys) sync_n <= 1'b0;
         repeat (4) @(negedge clk_sys);
         `CHK({f_rst, chan}, 5'h10)
         rd(`AUX_ADDR_DATA, 3 - k, v);
         res = 24'($urandom_range(24'hfeffff));
         @(posedge clk_sys) conv_result <= res;
         rd(`AUX_ADDR_MODE, 2, v);
         `CHK(v[10:8], 3'(dly))
         @(posedge clk_sys) sync_n <= 1'b1;
         for (n = 0; c_start !== 1'b1 && n < 9000; n++)
            @(negedge clk_sys);
         limit(n, 9000);
         `CHK(n >= tab[dly] && n <= tab[dly] + 10, 1'b1)
         for (n = 0; dout_rdy_n !== 1'b0 && n < 200; n++)
            @(negedge clk_sys);
         limit(n, 200);
         rd(`AUX_ADDR_DATA, 3 - k, v);
         `CHK(v, k ? 24'(16'((25'(res) + `AUX_ROUND_HALF) >> 8)) : res)
      end
      // Continuous read comes last: in that mode no frame can carry a write.
      wr(`AUX_ADDR_IFMODE, 16'h0088, 1'b0);
      aux_host_inst.xfer(48'h0, 32, r);
      `CHK(r, {16'h0000, v, sum8({`AUX_CONT_CMD, v}, 4, 1'b0)})
      print_verdict();
   end
endmodule

// *** tb/aux_host.sv ***
// Host side of the four-wire serial link: frames, clocks and shifts the bits.
// Assumes the device changes its data output on falling serial clock edges.
`timescale 1ns/1ns
module aux_host (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b1;
   end
   // Serial clock idles high and only runs inside a frame.
   task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
      rx = '0;
      #7 cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #15 sclk = 1'b0;
         din = tx[i];
         #15 sclk = 1'b1;
         rx = {rx[46:0], dout};
      end
      #15 cs_n = 1'b1;
      din = ~din;
      // The device needs several master clocks of deselect before the next frame.
      #300;
   endtask
endmodule
